// ### common/addr_match_if.sv
/*
 * Carries one address window (base, width code) and the live bus address
 * to a window matcher, and the hit back.
 * Assumes both ends sit on the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

interface addr_match_if;
    logic [10:0] base;
    logic [10:0] addr;
    logic [1:0]  width;
    logic        hit;

    modport owner   (output base, output addr, output width, input hit);
    modport matcher (input base, input addr, input width, output hit);
endinterface

`default_nettype wire

// ### common/gp_pin_pkg.sv
/*
 * Shared constants for the address-decoded general pin port: configuration
 * indices, field positions, reset values and pin function codes.
 * Assumes an 11-bit host I/O address and an 8-bit host data bus.
 */
`default_nettype none

package gp_pin_pkg;

    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;

    // Host I/O addresses of the configuration port; arbitrary defaults.
    localparam logic [10:0] UNLOCK_PORT_ADDR = 11'h2E0;
    localparam logic [10:0] INDEX_PORT_ADDR  = 11'h2E1;
    localparam logic [10:0] DATA_PORT_ADDR   = 11'h2E2;

    localparam logic [7:0] UNLOCK_VALUE = 8'h89;

    localparam logic [7:0] IDX_GP0_ADDR_LOW  = 8'h10;
    localparam logic [7:0] IDX_GP0_ADDR_HIGH = 8'h11;
    localparam logic [7:0] IDX_GP1_ADDR_LOW  = 8'h12;
    localparam logic [7:0] IDX_GP1_ADDR_HIGH = 8'h13;
    localparam logic [7:0] IDX_GP0_PIN_CFG   = 8'h14;

    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] HIGH_WR_MASK = 8'hC7;

    localparam int HIGH_ADDR_MSB = 2;
    localparam int WIDTH_LSB     = 6;
    localparam int FUNC_LSB      = 5;
    localparam int POL_BIT       = 4;
    localparam int QUAL_RD_BIT   = 3;
    localparam int QUAL_WR_BIT   = 2;
    localparam int INV_TO_BIT    = 1;
    localparam int INV_FROM_BIT  = 0;

    localparam logic [2:0] FUNC_OFF   = 3'h0;
    localparam logic [2:0] FUNC_OUT   = 3'h1;
    localparam logic [2:0] FUNC_IN    = 3'h2;
    localparam logic [2:0] FUNC_BIDIR = 3'h3;

    typedef struct packed {
        logic [10:0] sa;
        logic        aen_n;
        logic        ior_n;
        logic        iow_n;
        logic [7:0]  sd;
        logic        pin;
    } bus_sample_t;

    localparam bus_sample_t SAMPLE_IDLE = '{sa: 11'h000, aen_n: 1'b1, ior_n: 1'b1,
                                            iow_n: 1'b1, sd: 8'h00, pin: 1'b0};

endpackage

`default_nettype wire

// ### rtl/addr_window_match.sv
/*
 * Compares a bus address with a programmed base, ignoring 0 to 3 low bits
 * so that windows of 1, 2, 4 or 8 bytes match.
 * Assumes the address is already synchronised to the local clock.
 */
`timescale 1ns/1ps
`default_nettype none

module addr_window_match
    import gp_pin_pkg::*;
(
    addr_match_if.matcher m
);

    logic [ADDR_W-1:0] mask;

    always_comb
    begin
        mask  = {ADDR_W{1'b1}} << m.width;
        m.hit = ((m.addr ^ m.base) & mask) == '0;
    end

endmodule

`default_nettype wire

// ### rtl/isa_decoded_gp_pin_port.sv
/*
 * Address-decoded general pin port with its indexed configuration port.
 * Assumes asynchronous host strobes, resampled here through two flops, and
 * strobes held long enough for several clock cycles of sampling.
 */
// Overview of operation
// - Port zero low register holds address 7..0.
// - Port zero high bits 2..0 hold 10..8.
// - Port zero width code ignores 0..3 bits.
// - Port one low register holds address 7..0.
// - Port one high bits 2..0 hold 10..8.
// - Port one matches 1, 2, 4, 8 bytes.
// - Pin function: off, out, in, bidir, select.
// - Output mode drives written data bit to pin.
// - Input mode returns pin level on read.
// - Select asserts on address match when qualified.
// - Polarity bit picks low or high active.
// - Strobe bits: none, write, read, either.
// - Inversion bits for each data direction.
`timescale 1ns/1ps
`default_nettype none

module isa_decoded_gp_pin_port
    import gp_pin_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        sys_rst_i,
    // Host bus
    input  wire logic [10:0] sa_i,
    input  wire logic        aen_n_i,
    input  wire logic        ior_n_i,
    input  wire logic        iow_n_i,
    input  wire logic [7:0]  sd_i,
    output var  logic [7:0]  sd_o,
    output var  logic [7:0]  sd_oe_o,
    // General pin zero
    input  wire logic        gp_pin_i,
    output var  logic        gp_pin_o,
    output var  logic        gp_pin_oe_o,
    // Port one decode
    output var  logic        port1_hit_o
);

    bus_sample_t s1_q, s1_d, s2_q, s2_d;

    logic        iow_prev_q, iow_prev_d;
    logic [10:0] wr_addr_q, wr_addr_d;
    logic [7:0]  wr_data_q, wr_data_d;
    logic        wr_aen_n_q, wr_aen_n_d;
    logic        unlocked_q, unlocked_d;
    logic [7:0]  index_q, index_d;
    logic [7:0]  gp0_addr_low_q, gp0_addr_low_d;
    logic [7:0]  gp0_addr_high_mode_q, gp0_addr_high_mode_d;
    logic [7:0]  gp1_addr_low_q, gp1_addr_low_d;
    logic [7:0]  gp1_addr_high_mode_q, gp1_addr_high_mode_d;
    logic [7:0]  gp0_pin_config_q, gp0_pin_config_d;
    logic        pin_data_q, pin_data_d;
    logic        pin_out_d, pin_oe_d, port1_hit_d;
    logic [7:0]  sd_out_d, sd_oe_d;

    logic        commit;
    logic        rd_cycle;
    logic        wr_cycle;
    logic        cs_now;
    logic [7:0]  reg_rd;
    logic [2:0]  pin0_function_select;

    addr_match_if m0 ();
    addr_match_if m1 ();

    assign m0.base  = {gp0_addr_high_mode_q[HIGH_ADDR_MSB:0], gp0_addr_low_q};
    assign m0.width = gp0_addr_high_mode_q[WIDTH_LSB+1:WIDTH_LSB];
    assign m0.addr  = s2_q.sa;
    assign m1.base  = {gp1_addr_high_mode_q[HIGH_ADDR_MSB:0], gp1_addr_low_q};
    assign m1.width = gp1_addr_high_mode_q[WIDTH_LSB+1:WIDTH_LSB];
    assign m1.addr  = s2_q.sa;

    addr_window_match u_match0 (.m(m0));
    addr_window_match u_match1 (.m(m1));

    assign pin0_function_select = gp0_pin_config_q[FUNC_LSB+2:FUNC_LSB];

    // Host pins are asynchronous, so nothing reads the first stage but the second.
    always_comb
    begin
        s1_d = '{sa: sa_i, aen_n: aen_n_i, ior_n: ior_n_i, iow_n: iow_n_i, sd: sd_i, pin: gp_pin_i};
        s2_d = s1_q;
    end

    always_comb
    begin
        unique case (index_q)
            IDX_GP0_ADDR_LOW:  reg_rd = gp0_addr_low_q;
            IDX_GP0_ADDR_HIGH: reg_rd = gp0_addr_high_mode_q;
            IDX_GP1_ADDR_LOW:  reg_rd = gp1_addr_low_q;
            IDX_GP1_ADDR_HIGH: reg_rd = gp1_addr_high_mode_q;
            IDX_GP0_PIN_CFG:   reg_rd = gp0_pin_config_q;
            default:           reg_rd = REG_RESET;
        endcase
    end

    always_comb
    begin
        iow_prev_d           = s2_q.iow_n;
        wr_addr_d            = wr_addr_q;
        wr_data_d            = wr_data_q;
        wr_aen_n_d           = wr_aen_n_q;
        unlocked_d           = unlocked_q;
        index_d              = index_q;
        gp0_addr_low_d       = gp0_addr_low_q;
        gp0_addr_high_mode_d = gp0_addr_high_mode_q;
        gp1_addr_low_d       = gp1_addr_low_q;
        gp1_addr_high_mode_d = gp1_addr_high_mode_q;
        gp0_pin_config_d     = gp0_pin_config_q;
        pin_data_d           = pin_data_q;
        sd_out_d             = 8'h00;
        sd_oe_d              = 8'h00;
        pin_out_d            = 1'b0;
        pin_oe_d             = 1'b0;
        port1_hit_d          = !s2_q.aen_n && m1.hit;

        // Address and data are held while the write strobe is low and used at its release.
        if (!s2_q.iow_n)
        begin
            wr_addr_d  = s2_q.sa;
            wr_data_d  = s2_q.sd;
            wr_aen_n_d = s2_q.aen_n;
        end
        commit = !iow_prev_q && s2_q.iow_n && !wr_aen_n_q;

        if (commit)
        begin
            if (wr_addr_q == UNLOCK_PORT_ADDR)
            begin
                unlocked_d = (wr_data_q == UNLOCK_VALUE);
            end
            else if (unlocked_q && wr_addr_q == INDEX_PORT_ADDR)
            begin
                index_d = wr_data_q;
            end
            else if (unlocked_q && wr_addr_q == DATA_PORT_ADDR)
            begin
                unique case (index_q)
                    IDX_GP0_ADDR_LOW:  gp0_addr_low_d       = wr_data_q;
                    IDX_GP0_ADDR_HIGH: gp0_addr_high_mode_d = wr_data_q & HIGH_WR_MASK;
                    IDX_GP1_ADDR_LOW:  gp1_addr_low_d       = wr_data_q;
                    IDX_GP1_ADDR_HIGH: gp1_addr_high_mode_d = wr_data_q & HIGH_WR_MASK;
                    IDX_GP0_PIN_CFG:   gp0_pin_config_d     = wr_data_q;
                    default:           gp0_pin_config_d     = gp0_pin_config_q;
                endcase
            end
        end

        rd_cycle = !s2_q.aen_n && !s2_q.ior_n;
        wr_cycle = !s2_q.aen_n && !s2_q.iow_n && m0.hit;

        // Configuration port reads take precedence over the pin window.
        if (rd_cycle && unlocked_q && s2_q.sa == INDEX_PORT_ADDR)
        begin
            sd_out_d = index_q;
            sd_oe_d  = 8'hFF;
        end
        else if (rd_cycle && unlocked_q && s2_q.sa == DATA_PORT_ADDR)
        begin
            sd_out_d = reg_rd;
            sd_oe_d  = 8'hFF;
        end
        else if (rd_cycle && m0.hit && (pin0_function_select == FUNC_IN || pin0_function_select == FUNC_BIDIR))
        begin
            sd_out_d = {7'h00, s2_q.pin ^ gp0_pin_config_q[INV_FROM_BIT]};
            sd_oe_d  = 8'h01;
        end

        if (wr_cycle && (pin0_function_select == FUNC_OUT || pin0_function_select == FUNC_BIDIR))
        begin
            pin_data_d = s2_q.sd[0] ^ gp0_pin_config_q[INV_TO_BIT];
        end

        unique case ({gp0_pin_config_q[QUAL_RD_BIT], gp0_pin_config_q[QUAL_WR_BIT]})
            2'b00: cs_now = !s2_q.aen_n && m0.hit;
            2'b01: cs_now = !s2_q.aen_n && m0.hit && !s2_q.iow_n;
            2'b10: cs_now = !s2_q.aen_n && m0.hit && !s2_q.ior_n;
            2'b11: cs_now = !s2_q.aen_n && m0.hit && (!s2_q.ior_n || !s2_q.iow_n);
        endcase

        if (pin0_function_select[2])
        begin
            pin_oe_d  = 1'b1;
            pin_out_d = cs_now ~^ gp0_pin_config_q[POL_BIT];
        end
        else
        begin
            unique case (pin0_function_select)
                FUNC_OUT:
                begin
                    pin_oe_d  = 1'b1;
                    pin_out_d = pin_data_d;
                end
                FUNC_BIDIR:
                begin
                    pin_oe_d  = wr_cycle;
                    pin_out_d = pin_data_d;
                end
                default:
                begin
                    pin_oe_d  = 1'b0;
                    pin_out_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            s1_q                 <= SAMPLE_IDLE;
            s2_q                 <= SAMPLE_IDLE;
            iow_prev_q           <= 1'b1;
            wr_addr_q            <= 11'h000;
            wr_data_q            <= REG_RESET;
            wr_aen_n_q           <= 1'b1;
            unlocked_q           <= 1'b0;
            index_q              <= REG_RESET;
            gp0_addr_low_q       <= REG_RESET;
            gp0_addr_high_mode_q <= REG_RESET;
            gp1_addr_low_q       <= REG_RESET;
            gp1_addr_high_mode_q <= REG_RESET;
            gp0_pin_config_q     <= REG_RESET;
            pin_data_q           <= 1'b0;
            gp_pin_o             <= 1'b0;
            gp_pin_oe_o          <= 1'b0;
            sd_o                 <= 8'h00;
            sd_oe_o              <= 8'h00;
            port1_hit_o          <= 1'b0;
        end
        else
        begin
            s1_q                 <= s1_d;
            s2_q                 <= s2_d;
            iow_prev_q           <= iow_prev_d;
            wr_addr_q            <= wr_addr_d;
            wr_data_q            <= wr_data_d;
            wr_aen_n_q           <= wr_aen_n_d;
            unlocked_q           <= unlocked_d;
            index_q              <= index_d;
            gp0_addr_low_q       <= gp0_addr_low_d;
            gp0_addr_high_mode_q <= gp0_addr_high_mode_d;
            gp1_addr_low_q       <= gp1_addr_low_d;
            gp1_addr_high_mode_q <= gp1_addr_high_mode_d;
            gp0_pin_config_q     <= gp0_pin_config_d;
            pin_data_q           <= pin_data_d;
            gp_pin_o             <= pin_out_d;
            gp_pin_oe_o          <= pin_oe_d;
            sd_o                 <= sd_out_d;
            sd_oe_o              <= sd_oe_d;
            port1_hit_o          <= port1_hit_d;
        end
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (sys_rst_i);

    a_locked_no_write: assert property (
        (!unlocked_q && commit && wr_addr_q == DATA_PORT_ADDR) |=> $stable(gp0_pin_config_q))
        else $error("Locked data port write changed a register.");

    a_high_reserved_zero: assert property (
        (commit && unlocked_q && wr_addr_q == DATA_PORT_ADDR && index_q == IDX_GP0_ADDR_HIGH)
        |=> gp0_addr_high_mode_q == ($past(wr_data_q) & HIGH_WR_MASK))
        else $error("High address register write stored reserved bits.");

    a_decode_eight_byte: assert property (
        m0.hit |-> s2_q.sa[10:3] == {gp0_addr_high_mode_q[2:0], gp0_addr_low_q[7:3]})
        else $error("Pin window matched outside its eight-byte span.");

    a_port1_exact_hit: assert property (
        (!s2_q.aen_n && gp1_addr_high_mode_q[7:6] == 2'b00
         && s2_q.sa == {gp1_addr_high_mode_q[2:0], gp1_addr_low_q}) |=> port1_hit_o)
        else $error("Port one missed an exact address match.");

    a_tristate_when_off: assert property (
        (pin0_function_select == FUNC_OFF || pin0_function_select == FUNC_IN) |=> !gp_pin_oe_o)
        else $error("Pin driven in off or input function.");

    a_output_follows_write: assert property (
        (pin0_function_select == FUNC_OUT && wr_cycle)
        |=> gp_pin_oe_o && gp_pin_o == ($past(s2_q.sd[0]) ^ $past(gp0_pin_config_q[INV_TO_BIT])))
        else $error("Output pin does not carry the written bit.");

    a_input_read_data: assert property (
        (rd_cycle && m0.hit && pin0_function_select[2:1] == 2'b01
         && (!unlocked_q || (s2_q.sa != INDEX_PORT_ADDR && s2_q.sa != DATA_PORT_ADDR)))
        |=> sd_oe_o == 8'h01 && sd_o[0] == ($past(s2_q.pin) ^ $past(gp0_pin_config_q[INV_FROM_BIT])))
        else $error("Pin read returned the wrong level.");

    a_select_active_level: assert property (
        (pin0_function_select[2] && cs_now) |=> gp_pin_oe_o && gp_pin_o == $past(gp0_pin_config_q[POL_BIT]))
        else $error("Chip select not at its active level.");

    a_select_write_gate: assert property (
        (pin0_function_select[2] && gp0_pin_config_q[3:2] == 2'b01 && s2_q.iow_n)
        |=> gp_pin_o != $past(gp0_pin_config_q[POL_BIT]))
        else $error("Write-qualified select asserted without write strobe.");

    a_reset_tristate: assert property (disable iff (1'b0)
        sys_rst_i |=> !gp_pin_oe_o && sd_oe_o == 8'h00 && gp0_pin_config_q == REG_RESET)
        else $error("Pin or data bus driven after reset.");

    c_unlock: cover property (commit && wr_addr_q == UNLOCK_PORT_ADDR && wr_data_q == UNLOCK_VALUE);
    c_select: cover property (pin0_function_select[2] && cs_now);
    c_input_read: cover property (rd_cycle && m0.hit && pin0_function_select == FUNC_IN);
    c_bidir_write: cover property (wr_cycle && pin0_function_select == FUNC_BIDIR);

endmodule

`default_nettype wire

// ### tb/isa_decoded_gp_pin_port_tb.sv
/*
 * Self-checking bench for the address-decoded general pin port.
 * Assumes the host model in isa_host_model.sv and the gp_pin_pkg constants.
 */
`timescale 1ns/1ps
`default_nettype none

module isa_decoded_gp_pin_port_tb
    import gp_pin_pkg::*;
;
    logic        clk_sys     = 1'b0;
    logic        sys_rst     = 1'b1;
    logic [10:0] sa;
    logic        aen_n;
    logic        ior_n;
    logic        iow_n;
    logic [7:0]  host_sd;
    logic [7:0]  sd_bus;
    logic [7:0]  sd_o;
    logic [7:0]  sd_oe;
    logic        pin_ext     = 1'b0;
    logic        pin_in;
    logic        pin_o;
    logic        pin_oe;
    logic        hit1;
    logic [7:0]  q;
    logic [3:0]  m;
    int          failures    = 0;
    int          check_count = 0;
    int          cycles      = 0;

    // Rows: index, value written, value read back.
    localparam logic [23:0] ROWS [6] = '{24'h10_A5A5, 24'h11_FFC7, 24'h12_5A5A,
                                         24'h13_3F07, 24'h14_E7E7, 24'h15_FF00};

    assign sd_bus = (sd_oe & sd_o) | (~sd_oe & host_sd);
    assign pin_in = pin_oe ? pin_o : pin_ext;

    always #20 clk_sys = ~clk_sys;

    isa_decoded_gp_pin_port dut
    (
        .clk_sys_i   (clk_sys),
        .sys_rst_i   (sys_rst),
        .sa_i        (sa),
        .aen_n_i     (aen_n),
        .ior_n_i     (ior_n),
        .iow_n_i     (iow_n),
        .sd_i        (sd_bus),
        .sd_o        (sd_o),
        .sd_oe_o     (sd_oe),
        .gp_pin_i    (pin_in),
        .gp_pin_o    (pin_o),
        .gp_pin_oe_o (pin_oe),
        .port1_hit_o (hit1)
    );

    isa_host_model host
    (
        .clk_i   (clk_sys),
        .sa_o    (sa),
        .aen_n_o (aen_n),
        .ior_n_o (ior_n),
        .iow_n_o (iow_n),
        .sd_o    (host_sd),
        .sd_i    (sd_bus),
        .mon_i   ({hit1, pin_oe, pin_o, sd_oe[0]})
    );

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] val);
        host.io(1'b1, UNLOCK_PORT_ADDR, UNLOCK_VALUE, q, m);
        host.io(1'b1, INDEX_PORT_ADDR, idx, q, m);
        host.io(1'b1, DATA_PORT_ADDR, val, q, m);
    endtask

    task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] val);
        host.io(1'b1, UNLOCK_PORT_ADDR, UNLOCK_VALUE, q, m);
        host.io(1'b1, INDEX_PORT_ADDR, idx, q, m);
        host.io(1'b0, DATA_PORT_ADDR, 8'h00, val, m);
    endtask

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // The whole run needs about 2400 clocks; the ceiling leaves ample margin.
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    initial
    begin
        logic [7:0]  v;
        logic        act;
        logic [10:0] lo;
        logic [10:0] hi;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            cfg_rd(ROWS[i][23:16], v);
            check("reset value", v, REG_RESET);
        end
        for (int i = 0; i < 6; i++)
        begin
            cfg_wr(ROWS[i][23:16], ROWS[i][15:8]);
            cfg_rd(ROWS[i][23:16], v);
            check("register readback", v, ROWS[i][7:0]);
        end
        host.io(1'b1, UNLOCK_PORT_ADDR, 8'h00, q, m);
        host.io(1'b1, INDEX_PORT_ADDR, IDX_GP0_ADDR_LOW, q, m);
        host.io(1'b1, DATA_PORT_ADDR, 8'h00, q, m);
        host.io(1'b0, DATA_PORT_ADDR, 8'h00, q, m);
        check("locked read enable", {7'h00, m[0]}, 8'h00);
        cfg_rd(IDX_GP0_ADDR_LOW, v);
        check("locked write", v, 8'hA5);
        cfg_wr(IDX_GP0_ADDR_LOW, 8'h23);
        cfg_wr(IDX_GP1_ADDR_LOW, 8'h45);
        cfg_wr(IDX_GP0_PIN_CFG, 8'h40);
        for (int w = 0; w < 4; w++)
        begin
            lo = 11'((1 << w) - 1);
            hi = 11'(1 << w);
            cfg_wr(IDX_GP0_ADDR_HIGH, {2'(w), 6'h01});
            cfg_wr(IDX_GP1_ADDR_HIGH, {2'(w), 6'h03});
            for (int p = 0; p < 2; p++)
            begin
                host.io(1'b0, (p ? 11'h345 : 11'h123) ^ lo, 8'h00, q, m);
                check("window inside", {7'h00, p ? m[3] : m[0]}, 8'h01);
                host.io(1'b0, (p ? 11'h345 : 11'h123) ^ hi, 8'h00, q, m);
                check("window outside", {7'h00, p ? m[3] : m[0]}, 8'h00);
            end
        end
        for (int k = 0; k < 4; k++)
        begin
            cfg_wr(IDX_GP0_PIN_CFG, 8'h40 | 8'(k >> 1));
            pin_ext = k[0];
            host.io(1'b0, 11'h123, 8'h00, q, m);
            check("pin read", {7'h00, q[0]}, {7'h00, k[0] ^ k[1]});
            check("input pin drive", {7'h00, m[2]}, 8'h00);
        end
        for (int k = 0; k < 4; k++)
        begin
            cfg_wr(IDX_GP0_PIN_CFG, 8'h20 | 8'((k >> 1) << 1));
            host.io(1'b1, 11'h123, {7'h7F, k[0]}, q, m);
            check("output pin", {6'h00, pin_oe, pin_o}, {6'h00, 1'b1, k[0] ^ k[1]});
        end
        cfg_wr(IDX_GP0_PIN_CFG, 8'h60);
        pin_ext = 1'b0;
        host.io(1'b1, 11'h123, 8'h01, q, m);
        check("bidir write", {6'h00, m[2:1]}, 8'h03);
        pin_ext = 1'b1;
        host.io(1'b0, 11'h123, 8'h00, q, m);
        check("bidir read", {6'h00, m[2], q[0]}, 8'h01);
        cfg_wr(IDX_GP0_PIN_CFG, 8'h00);
        host.io(1'b1, 11'h123, 8'h01, q, m);
        check("off pin drive", {7'h00, m[2]}, 8'h00);
        for (int k = 0; k < 8; k++)
        begin
            cfg_wr(IDX_GP0_PIN_CFG, 8'h80 | 8'(k << 2) | 8'((k & 3) << 5));
            for (int r = 0; r < 3; r++)
            begin
                host.io(r == 0, r == 2 ? 11'h200 : 11'h123, 8'h00, q, m);
                act = (r < 2) && ((k & 3) == 0 || (r == 0 ? k[0] : k[1]));
                check("select level", {6'h00, m[2:1]}, {6'h00, 1'b1, act ~^ k[2]});
            end
        end
        @(negedge clk_sys);
        sys_rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        sys_rst = 1'b0;
        check("reset pin drive", {7'h00, pin_oe}, 8'h00);
        cfg_rd(IDX_GP0_PIN_CFG, v);
        check("reset pin config", v, REG_RESET);
        end_sim();
    end
endmodule

`default_nettype wire

// ### tb/isa_host_model.sv
/*
 * Host bus master model that issues I/O read and write cycles on demand.
 * Assumes the bench resolves the shared data bus and calls io() from one process.
 */
`timescale 1ns/1ps
`default_nettype none

module isa_host_model
(
    // Clock
    input  wire logic        clk_i,
    // Host bus
    output var  logic [10:0] sa_o,
    output var  logic        aen_n_o,
    output var  logic        ior_n_o,
    output var  logic        iow_n_o,
    output var  logic [7:0]  sd_o,
    input  wire logic [7:0]  sd_i,
    // Device outputs seen mid-cycle
    input  wire logic [3:0]  mon_i
);
    initial
    begin
        sa_o    = 11'h000;
        aen_n_o = 1'b1;
        ior_n_o = 1'b1;
        iow_n_o = 1'b1;
        sd_o    = 8'h00;
    end

    // Strobes stay low six clocks and high six, above what the synchronisers need.
    task automatic io(input logic wr, input logic [10:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic [3:0] m);
        @(negedge clk_i);
        sa_o    = a;
        aen_n_o = 1'b0;
        // A read leaves the data lines to the device, so undriven bits show the inverse of d.
        sd_o    = wr ? d : ~d;
        if (wr)
            iow_n_o = 1'b0;
        else
            ior_n_o = 1'b0;
        repeat (5) @(negedge clk_i);
        q = sd_i;
        m = mon_i;
        @(negedge clk_i);
        ior_n_o = 1'b1;
        iow_n_o = 1'b1;
        @(negedge clk_i);
        // Released lines show the inverse so a stale value cannot pass for a held one.
        aen_n_o = 1'b1;
        sa_o    = ~a;
        sd_o    = ~d;
        repeat (4) @(negedge clk_i);
    endtask
endmodule

`default_nettype wire
